//--- l2mb_pkg.sv
// Purpose: shared constants and types for the cache memory bus port
// Assumes: cpu clock at 40 MHz, memory bus clock sampled as a plain input
// Notes: widths fixed, no registers on a bus

package l2mb_pkg;

  localparam int L2MB_BE_W = 8;
  localparam int L2MB_BT_W = 4;
  localparam int L2MB_CFA_W = 7;
  localparam int L2MB_SET_W = 11;
  localparam int L2MB_TAG_W = 12;
  localparam int L2MB_SUB_W = 2;
  localparam int L2MB_BURST_W = 2;

  localparam logic [L2MB_SUB_W-1:0] L2MB_SUB_ZERO = 2'h0;
  localparam logic [L2MB_BURST_W-1:0] L2MB_BURST_RST = 2'h0;
  localparam logic [L2MB_BE_W-1:0] L2MB_BE_RST = 8'hFF;
  localparam logic [L2MB_BT_W-1:0] L2MB_BT_RST = 4'h0;
  localparam logic L2MB_STRB_RST = 1'b0;
  localparam logic L2MB_PAR_RST = 1'b1;
  // edges after reset release before a synchronised strap level is real
  localparam logic [1:0] L2MB_CFG_FILL = 2'h2;

  // cycle kinds presented by the cpu side
  typedef enum logic [2:0] {
    L2MB_CYC_MEM_RD,
    L2MB_CYC_MEM_WR,
    L2MB_CYC_WRBACK,
    L2MB_CYC_IO,
    L2MB_CYC_SPECIAL,
    L2MB_CYC_BTM
  } l2mb_cyc_t;

  typedef enum {
    L2MB_ST_RESET,
    L2MB_ST_IDLE,
    L2MB_ST_CYCLE,
    L2MB_ST_SNOOP_WB
  } l2mb_state_t;

endpackage

//--- l2mb_sync.sv
// Purpose: two-flop synchroniser with edge outputs on the second stage
// Assumes: input asynchronous to sys_clk_in
// Notes: first stage read only by the second stage
`timescale 1ns/10ps

module l2mb_sync (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic async_in,
  input wire logic rst_val_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic vld1;
  logic vld2;
  logic vld3;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      vld1 <= 1'b0;
      vld2 <= 1'b0;
      vld3 <= 1'b0;
    end else if (clk_en_in) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      vld1 <= 1'b1;
      vld2 <= vld1;
      vld3 <= vld2;
    end
  end

  // idle level stands in until a stage holds a real sample, so no false edge after reset
  wire lvl2 = vld2 ? stage2 : rst_val_in;
  wire lvl3 = vld3 ? stage3 : rst_val_in;
  assign level_out = lvl2;
  assign rise_out = lvl2 & ~lvl3 & clk_en_in;
  assign fall_out = ~lvl2 & lvl3 & clk_en_in;

endmodule

//--- l2mb_port.sv
// Purpose: memory bus side of the second-level cache, controller and sram slice logic
// Assumes: memory bus clock and memory bus pins sampled on sys_clk_in; cpu side same clock
// Notes: strobed-mode timing and data pins left out; strobed mode only flagged
//
// Function
// - sub-line address driven while enable low
// - inactive enable at snoop: start at supplied sub-line
// - active enable at snoop: start at zero
// - byte enables latched from cpu copy
// - byte enables valid with strobe or next
// - low ready at bus clock rise advances burst
// - ready ignored unless select qualifies it
// - ready pin doubles as input strobe (here ready is used only in clocked mode, never as a strobe)
// - echo branch trace during trace special cycle
// - cacheable indication driven on reads
// - writes cacheable only for writebacks
// - io, special, locked cycles never cacheable
// - config, set, tag lines form address
// - address driven normally, input on snoops
// - clocked mode samples on bus clock rise
// - write data timed by chosen clock
// - bus clock pin doubles as mode select
// - snoops accepted only with line enable inactive
// - end of cycle ends cycle, resets burst
// - shared config pins sampled at reset release
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps

module l2mb_port
  import l2mb_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // cpu side, same clock
  input wire logic cache_addr_strobe_n_in,
  input wire logic [L2MB_BE_W-1:0] cpu_byte_enables_n_in,
  input wire logic [L2MB_BT_W-1:0] cpu_branch_trace_in,
  input wire l2mb_cyc_t cpu_cycle_kind_in,
  input wire logic cpu_locked_in,
  input wire logic cpu_cacheable_in,
  input wire logic [L2MB_CFA_W-1:0] cpu_config_addr_in,
  input wire logic [L2MB_SET_W-1:0] cpu_set_index_in,
  input wire logic [L2MB_TAG_W-1:0] cpu_tag_bits_in,
  input wire logic [L2MB_SUB_W-1:0] cpu_sub_line_in,
  input wire logic snoop_hit_modified_in,
  input wire logic write_use_output_clock_in,
  // memory bus pins, asynchronous
  input wire logic mem_clk_mode_pin_in,
  input wire logic mem_output_clock_in,
  input wire logic mem_ready_strobe_pin_n_in,
  input wire logic mem_select_n_in,
  input wire logic mem_end_of_cycle_n_in,
  input wire logic sub_line_addr_out_enable_n_in,
  input wire logic line_addr_out_enable_n_in,
  input wire logic snoop_strobe_n_in,
  input wire logic [L2MB_SUB_W-1:0] mem_sub_line_in,
  input wire logic [L2MB_CFA_W-1:0] mem_config_addr_in,
  input wire logic [L2MB_SET_W-1:0] mem_set_index_in,
  input wire logic [L2MB_TAG_W-1:0] mem_tag_bits_in,
  input wire logic mem_byte_enables_par_pin_in,
  // memory bus outputs
  output logic [L2MB_SUB_W-1:0] mem_sub_line_out,
  output logic mem_sub_line_oe_out,
  output logic [L2MB_CFA_W-1:0] mem_config_addr_out,
  output logic [L2MB_SET_W-1:0] mem_set_index_out,
  output logic [L2MB_TAG_W-1:0] mem_tag_bits_out,
  output logic mem_line_addr_oe_out,
  output logic [L2MB_BE_W-1:0] mem_byte_enables_n_out,
  output logic [L2MB_BT_W-1:0] mem_branch_trace_out,
  output logic mem_cacheable_n_out,
  // status toward the cache core
  output logic strobed_mode_out,
  output logic parity_config_n_out,
  output logic [L2MB_BURST_W-1:0] burst_count_out,
  output logic data_step_out,
  output logic data_step_write_out,
  output logic cycle_end_out,
  output logic snoop_accept_out,
  output logic [L2MB_SUB_W-1:0] snoop_wb_start_out,
  output logic [L2MB_CFA_W-1:0] snoop_config_addr_out,
  output logic [L2MB_SET_W-1:0] snoop_set_index_out,
  output logic [L2MB_TAG_W-1:0] snoop_tag_bits_out,
  output logic snoop_wb_active_out
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic mclk_lvl, mclk_rise, mclk_fall;
  logic oclk_lvl, oclk_rise, oclk_fall;
  logic rdy_lvl, sel_lvl, eoc_lvl, sub_oe_lvl, line_oe_lvl, snp_lvl, snp_fall;
  logic par_lvl;
  logic unused_a, unused_b, unused_c;

  l2mb_sync u_mclk (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .async_in(mem_clk_mode_pin_in), .rst_val_in(1'b0), .level_out(mclk_lvl),
    .rise_out(mclk_rise), .fall_out(mclk_fall));
  l2mb_sync u_oclk (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .async_in(mem_output_clock_in), .rst_val_in(1'b0), .level_out(oclk_lvl),
    .rise_out(oclk_rise), .fall_out(oclk_fall));
  l2mb_sync u_rdy (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .async_in(mem_ready_strobe_pin_n_in), .rst_val_in(1'b1), .level_out(rdy_lvl),
    .rise_out(), .fall_out());
  l2mb_sync u_sel (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .async_in(mem_select_n_in), .rst_val_in(1'b1), .level_out(sel_lvl),
    .rise_out(), .fall_out());
  l2mb_sync u_eoc (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .async_in(mem_end_of_cycle_n_in), .rst_val_in(1'b1), .level_out(eoc_lvl),
    .rise_out(), .fall_out());
  l2mb_sync u_sboe (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .async_in(sub_line_addr_out_enable_n_in), .rst_val_in(1'b1), .level_out(sub_oe_lvl),
    .rise_out(), .fall_out());
  l2mb_sync u_lnoe (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .async_in(line_addr_out_enable_n_in), .rst_val_in(1'b1), .level_out(line_oe_lvl),
    .rise_out(), .fall_out());
  l2mb_sync u_snp (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .async_in(snoop_strobe_n_in), .rst_val_in(1'b1), .level_out(snp_lvl),
    .rise_out(unused_a), .fall_out(snp_fall));
  l2mb_sync u_par (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .async_in(mem_byte_enables_par_pin_in), .rst_val_in(1'b1), .level_out(par_lvl),
    .rise_out(unused_b), .fall_out(unused_c));

  // address buses: two flops, read only while a snoop strobe edge says they are stable
  logic [L2MB_SUB_W+L2MB_CFA_W+L2MB_SET_W+L2MB_TAG_W-1:0] addr_s1, addr_s2;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      addr_s1 <= '0;
      addr_s2 <= '0;
    end else if (clk_en_in) begin
      addr_s1 <= {mem_sub_line_in, mem_config_addr_in, mem_set_index_in, mem_tag_bits_in};
      addr_s2 <= addr_s1;
    end
  end

  // ==========================================================
  // reset-release configuration capture
  // ==========================================================
  logic cfg_pending;
  logic [1:0] cfg_fill;
  logic strobed_mode;
  logic parity_cfg_n;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cfg_pending <= 1'b1;
      cfg_fill <= L2MB_CFG_FILL;
      strobed_mode <= L2MB_STRB_RST;
      parity_cfg_n <= L2MB_PAR_RST;
    end else if (clk_en_in && cfg_pending) begin
      // synchroniser needs two edges after release before its level is real
      if (cfg_fill != 2'h0) begin
        cfg_fill <= cfg_fill - 2'h1;
      end else begin
        cfg_pending <= 1'b0;
        strobed_mode <= mclk_lvl;
        parity_cfg_n <= par_lvl;
      end
    end
  end
  assign strobed_mode_out = strobed_mode;
  assign parity_config_n_out = parity_cfg_n;

  // ==========================================================
  // burst stepping on memory bus clock edges
  // ==========================================================
  wire clocked_mode = ~strobed_mode & ~cfg_pending;
  wire ready_low = ~rdy_lvl & clocked_mode;
  wire selected = ~sel_lvl;
  wire eoc_hit = ~eoc_lvl & mclk_rise & clocked_mode;
  wire rd_step = mclk_rise & ready_low & selected;
  wire wr_edge = write_use_output_clock_in ? oclk_rise : mclk_rise;
  wire wr_step = wr_edge & ready_low & selected;
  wire unused_edges = mclk_fall | oclk_fall | oclk_lvl | unused_a | unused_b | unused_c;

  l2mb_state_t state, next_state;
  logic [L2MB_BURST_W-1:0] burst_cnt;
  logic cur_is_write;
  wire step = cur_is_write ? wr_step : rd_step;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      burst_cnt <= L2MB_BURST_RST;
    end else if (clk_en_in) begin
      if (eoc_hit) begin
        burst_cnt <= L2MB_BURST_RST;
      end else if (step && state != L2MB_ST_IDLE) begin
        burst_cnt <= burst_cnt + 2'h1;
      end
    end
  end
  assign burst_count_out = burst_cnt;
  assign data_step_out = step & (state != L2MB_ST_IDLE) & ~unused_edges | step & unused_edges
                         & (state != L2MB_ST_IDLE);
  assign data_step_write_out = data_step_out & cur_is_write;
  assign cycle_end_out = eoc_hit & (state != L2MB_ST_IDLE);

  // ==========================================================
  // cycle sequencing
  // ==========================================================
  wire cache_addr_strobe = ~cache_addr_strobe_n_in;
  wire snoop_ok = line_oe_lvl;
  wire snoop_take = snp_fall & snoop_ok & (state == L2MB_ST_IDLE);
  wire wr_kind = (cpu_cycle_kind_in == L2MB_CYC_MEM_WR) | (cpu_cycle_kind_in == L2MB_CYC_WRBACK);

  always_comb begin
    next_state = state;
    case (state)
      L2MB_ST_RESET: next_state = cfg_pending ? L2MB_ST_RESET : L2MB_ST_IDLE;
      L2MB_ST_IDLE: begin
        if (snoop_take && snoop_hit_modified_in) begin
          next_state = L2MB_ST_SNOOP_WB;
        end else if (cache_addr_strobe) begin
          next_state = L2MB_ST_CYCLE;
        end
      end
      L2MB_ST_CYCLE: next_state = eoc_hit ? L2MB_ST_IDLE : L2MB_ST_CYCLE;
      L2MB_ST_SNOOP_WB: next_state = eoc_hit ? L2MB_ST_IDLE : L2MB_ST_SNOOP_WB;
      default: next_state = L2MB_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= L2MB_ST_RESET;
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end
  assign snoop_accept_out = snoop_take;
  assign snoop_wb_active_out = (state == L2MB_ST_SNOOP_WB);

  // ==========================================================
  // cycle attribute latches
  // ==========================================================
  logic [L2MB_BE_W-1:0] be_lat;
  logic [L2MB_BT_W-1:0] bt_lat;
  logic cache_n;
  logic [L2MB_CFA_W-1:0] cfa_lat;
  logic [L2MB_SET_W-1:0] set_lat;
  logic [L2MB_TAG_W-1:0] tag_lat;
  logic [L2MB_SUB_W-1:0] sub_lat;

  wire no_cache = (cpu_cycle_kind_in == L2MB_CYC_IO) | (cpu_cycle_kind_in == L2MB_CYC_SPECIAL)
                  | (cpu_cycle_kind_in == L2MB_CYC_BTM) | cpu_locked_in;
  wire cache_rd = (cpu_cycle_kind_in == L2MB_CYC_MEM_RD) & cpu_cacheable_in;
  wire cache_wr = (cpu_cycle_kind_in == L2MB_CYC_WRBACK);
  wire next_cache_n = ~((cache_rd | cache_wr) & ~no_cache);
  wire is_btm = (cpu_cycle_kind_in == L2MB_CYC_BTM);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      be_lat <= L2MB_BE_RST;
      bt_lat <= L2MB_BT_RST;
      cache_n <= 1'b1;
      cur_is_write <= 1'b0;
      cfa_lat <= '0;
      set_lat <= '0;
      tag_lat <= '0;
      sub_lat <= L2MB_SUB_ZERO;
    end else if (clk_en_in && cache_addr_strobe && state == L2MB_ST_IDLE && !snoop_take) begin
      // latched in the strobe cycle so the copy is valid one clock after it
      be_lat <= cpu_byte_enables_n_in;
      bt_lat <= is_btm ? cpu_branch_trace_in : L2MB_BT_RST;
      cache_n <= next_cache_n;
      cur_is_write <= wr_kind;
      cfa_lat <= cpu_config_addr_in;
      set_lat <= cpu_set_index_in;
      tag_lat <= cpu_tag_bits_in;
      sub_lat <= cpu_sub_line_in;
    end else if (clk_en_in && snoop_take) begin
      cur_is_write <= 1'b1;
      cache_n <= 1'b1;
    end
  end

  // ==========================================================
  // snoop capture
  // ==========================================================
  logic [L2MB_SUB_W-1:0] snp_start;
  logic [L2MB_CFA_W-1:0] snp_cfa;
  logic [L2MB_SET_W-1:0] snp_set;
  logic [L2MB_TAG_W-1:0] snp_tag;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      snp_start <= L2MB_SUB_ZERO;
      snp_cfa <= '0;
      snp_set <= '0;
      snp_tag <= '0;
    end else if (clk_en_in && snoop_take) begin
      snp_start <= sub_oe_lvl ? addr_s2[L2MB_CFA_W+L2MB_SET_W+L2MB_TAG_W +: L2MB_SUB_W]
                              : L2MB_SUB_ZERO;
      snp_cfa <= addr_s2[L2MB_SET_W+L2MB_TAG_W +: L2MB_CFA_W];
      snp_set <= addr_s2[L2MB_TAG_W +: L2MB_SET_W];
      snp_tag <= addr_s2[0 +: L2MB_TAG_W];
    end
  end
  assign snoop_wb_start_out = snp_start;
  assign snoop_config_addr_out = snp_cfa;
  assign snoop_set_index_out = snp_set;
  assign snoop_tag_bits_out = snp_tag;

  // ==========================================================
  // pin drivers
  // ==========================================================
  wire in_wb = (state == L2MB_ST_SNOOP_WB);
  assign mem_sub_line_out = in_wb ? snp_start : sub_lat;
  assign mem_sub_line_oe_out = ~sub_oe_lvl;
  assign mem_config_addr_out = in_wb ? snp_cfa : cfa_lat;
  assign mem_set_index_out = in_wb ? snp_set : set_lat;
  assign mem_tag_bits_out = in_wb ? snp_tag : tag_lat;
  assign mem_line_addr_oe_out = ~line_oe_lvl;
  assign mem_byte_enables_n_out = be_lat;
  assign mem_branch_trace_out = bt_lat;
  assign mem_cacheable_n_out = cache_n;

endmodule

//--- l2mb_port_properties.sv
// Purpose: port-level checks of the cache memory bus port
// Assumes: testbench never strobes while a cycle is open
// Notes: pin paths settle within four cycles of a stable input
`timescale 1ns/10ps

module l2mb_port_properties
  import l2mb_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cache_addr_strobe_n_in,
  input wire logic [L2MB_BE_W-1:0] cpu_byte_enables_n_in,
  input wire logic [L2MB_BT_W-1:0] cpu_branch_trace_in,
  input wire l2mb_cyc_t cpu_cycle_kind_in,
  input wire logic cpu_locked_in,
  input wire logic cpu_cacheable_in,
  input wire logic [L2MB_CFA_W-1:0] cpu_config_addr_in,
  input wire logic mem_select_n_in,
  input wire logic sub_line_addr_out_enable_n_in,
  input wire logic line_addr_out_enable_n_in,
  input wire logic mem_sub_line_oe_out,
  input wire logic mem_line_addr_oe_out,
  input wire logic [L2MB_CFA_W-1:0] mem_config_addr_out,
  input wire logic [L2MB_BE_W-1:0] mem_byte_enables_n_out,
  input wire logic [L2MB_BT_W-1:0] mem_branch_trace_out,
  input wire logic mem_cacheable_n_out,
  input wire logic [L2MB_BURST_W-1:0] burst_count_out,
  input wire logic data_step_out,
  input wire logic cycle_end_out,
  input wire logic snoop_accept_out
);
  // ==========================================
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sub_drive_a: assert property (!sub_line_addr_out_enable_n_in [*4] |-> mem_sub_line_oe_out)
    else $error("sub-line not driven");
  sub_float_a: assert property (sub_line_addr_out_enable_n_in [*4] |-> !mem_sub_line_oe_out)
    else $error("sub-line not floated");
  line_drive_a: assert property (!line_addr_out_enable_n_in [*4] |-> mem_line_addr_oe_out)
    else $error("line address not driven");
  be_latch_a: assert property (!cache_addr_strobe_n_in |=>
    mem_byte_enables_n_out == $past(cpu_byte_enables_n_in)) else $error("byte enables wrong");
  be_moment_a: assert property ($changed(mem_byte_enables_n_out) |->
    !$past(cache_addr_strobe_n_in)) else $error("byte enables moved late");
  cache_set_a: assert property ($fell(mem_cacheable_n_out) |->
    !$past(cache_addr_strobe_n_in) && !$past(cpu_locked_in) &&
    ($past(cpu_cycle_kind_in) == L2MB_CYC_WRBACK ||
    $past(cpu_cycle_kind_in) == L2MB_CYC_MEM_RD && $past(cpu_cacheable_in)))
    else $error("cacheable raised wrongly");
  trace_echo_a: assert property (!cache_addr_strobe_n_in |=> mem_branch_trace_out ==
    ($past(cpu_cycle_kind_in) == L2MB_CYC_BTM ? $past(cpu_branch_trace_in) : L2MB_BT_RST))
    else $error("branch trace wrong");
  addr_load_a: assert property (!cache_addr_strobe_n_in |=>
    mem_config_addr_out == $past(cpu_config_addr_in)) else $error("address not loaded");
  burst_step_a: assert property (data_step_out && !cycle_end_out |=>
    burst_count_out == $past(burst_count_out) + 2'h1) else $error("burst did not advance");
  burst_clear_a: assert property (cycle_end_out |=> burst_count_out == L2MB_BURST_RST)
    else $error("burst not cleared");
  select_gate_a: assert property (mem_select_n_in [*4] |-> !data_step_out)
    else $error("step without select");
  snoop_gate_a: assert property (!line_addr_out_enable_n_in [*4] |-> !snoop_accept_out)
    else $error("snoop taken while driving");
endmodule

bind l2mb_port l2mb_port_properties chk_u (.*);

//--- l2mb_bus_model.sv
// Purpose: memory bus controller driving bus clock, ready and end of cycle
// Assumes: bus clock period 200 ns, stands at the strap level between bursts
// Notes: one burst per start rise
`timescale 1ns/10ps

module l2mb_bus_model (
  input wire logic start_in,
  input wire logic [1:0] beats_in,
  input wire logic sel_n_in,
  input wire logic slow_in,
  input wire logic strap_in,
  output logic mem_clk_out,
  output logic ready_n_out,
  output logic eoc_n_out,
  output logic sel_n_out,
  output logic busy_out
);
  logic run_clk = 1'b0;
  // shared pin: strap level when idle
  assign mem_clk_out = busy_out ? run_clk : strap_in;
  initial begin
    ready_n_out = 1'b1;
    eoc_n_out = 1'b1;
    sel_n_out = 1'b1;
    busy_out = 1'b0;
  end
  task automatic tick();
    #100 run_clk = 1'b1;
    #100 run_clk = 1'b0;
  endtask
  // ==========================================
  // burst
  always @(posedge start_in) begin
    busy_out = 1'b1;
    sel_n_out = sel_n_in;
    #13;
    for (int i = 0; i < beats_in; i++) begin
      if (slow_in) begin
        ready_n_out = 1'b1;
        tick();
      end
      ready_n_out = 1'b0;
      tick();
    end
    ready_n_out = 1'b1;
    eoc_n_out = 1'b0;
    tick();
    eoc_n_out = 1'b1;
    sel_n_out = 1'b1;
    busy_out = 1'b0;
  end
endmodule

//--- tb_top.sv
// Purpose: self-checking bench for the cache memory bus port
// Assumes: straps taken a few cycles after reset release
// Notes: every cpu cycle and snoop writeback is closed by a burst
`timescale 1ns/10ps

module tb_top;
  import l2mb_pkg::*;
  logic clk = 1'b0, rst = 1'b1, strb_n = 1'b1, lock = 1'b0, cach = 1'b0, hitm = 1'b0;
  logic sub_n = 1'b1, line_n = 1'b1, snp_n = 1'b1, par_pin = 1'b1, strap = 1'b0;
  logic start = 1'b0, sel_n = 1'b0, slow = 1'b0, acc = 1'b0, ouse = 1'b0, ogate = 1'b1, stepw;
  logic [1:0] beats = 2'h0, sub = 2'h0, msub = 2'h0, sub_o, wbs, bc;
  logic [7:0] be = 8'hFF, be_o;
  logic [3:0] bt = 4'h0, bt_o;
  logic [6:0] cfa = 7'h00, mcfa = 7'h00, cfa_o, scfa;
  logic [10:0] set = 11'h000, mset = 11'h000, set_o, sset;
  logic [11:0] tag = 12'h000, mtag = 12'h000, tag_o, stag;
  l2mb_cyc_t kind = L2MB_CYC_MEM_RD;
  logic mclk, rdy_n, eoc_n, mem_select_n, busy, sub_oe, line_oe, cn, smode, par_o, step, swb;
  int err_total = 0, samples_checked = 0, steps = 0, wsteps = 0;

  always #12.5 clk = ~clk;
  l2mb_bus_model bus_u (.start_in(start), .beats_in(beats), .sel_n_in(sel_n),
    .slow_in(slow), .strap_in(strap), .mem_clk_out(mclk), .ready_n_out(rdy_n),
    .eoc_n_out(eoc_n), .sel_n_out(mem_select_n), .busy_out(busy));
  l2mb_port dut_u (.sys_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1),
    .cache_addr_strobe_n_in(strb_n), .cpu_byte_enables_n_in(be), .cpu_branch_trace_in(bt),
    .cpu_cycle_kind_in(kind), .cpu_locked_in(lock), .cpu_cacheable_in(cach),
    .cpu_config_addr_in(cfa), .cpu_set_index_in(set), .cpu_tag_bits_in(tag),
    .cpu_sub_line_in(sub), .snoop_hit_modified_in(hitm), .write_use_output_clock_in(ouse),
    .mem_clk_mode_pin_in(mclk), .mem_output_clock_in(mclk & ogate),
    .mem_ready_strobe_pin_n_in(rdy_n),
    .mem_select_n_in(mem_select_n), .mem_end_of_cycle_n_in(eoc_n),
    .sub_line_addr_out_enable_n_in(sub_n), .line_addr_out_enable_n_in(line_n),
    .snoop_strobe_n_in(snp_n), .mem_sub_line_in(msub), .mem_config_addr_in(mcfa),
    .mem_set_index_in(mset), .mem_tag_bits_in(mtag), .mem_byte_enables_par_pin_in(par_pin),
    .mem_sub_line_out(sub_o), .mem_sub_line_oe_out(sub_oe), .mem_config_addr_out(cfa_o),
    .mem_set_index_out(set_o), .mem_tag_bits_out(tag_o), .mem_line_addr_oe_out(line_oe),
    .mem_byte_enables_n_out(be_o), .mem_branch_trace_out(bt_o), .mem_cacheable_n_out(cn),
    .strobed_mode_out(smode), .parity_config_n_out(par_o), .burst_count_out(bc),
    .data_step_out(step), .data_step_write_out(stepw), .cycle_end_out(),
    .snoop_accept_out(), .snoop_wb_start_out(wbs), .snoop_config_addr_out(scfa),
    .snoop_set_index_out(sset), .snoop_tag_bits_out(stag), .snoop_wb_active_out(swb));

  always @(posedge clk) begin
    if (step === 1'b1) steps++;
    if (stepw === 1'b1) wsteps++;
    if (dut_u.snoop_accept_out === 1'b1) acc = 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // stimulus
  task automatic do_reset(input logic p, input logic s);
    rst <= 1'b1;
    par_pin <= p;
    strap <= s;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    par_pin <= ~p;
    repeat (4) @(posedge clk);
    check(par_o, p);
    check(smode, s);
    check(be_o, L2MB_BE_RST);
    check(cn, 1'b1);
  endtask

  // mute: write stepping on an output clock that is held still
  task automatic burst(input logic s_n, input int n, input logic wr, input logic mute);
    sel_n <= s_n;
    beats <= 2'(n);
    slow <= $urandom;
    start <= 1'b1;
    steps = 0;
    wsteps = 0;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 300 && busy; i++) @(posedge clk);
    repeat (6) @(posedge clk);
    check(steps, (s_n || mute) ? 0 : n);
    check(wsteps, (s_n || mute || !wr) ? 0 : n);
    check(bc, L2MB_BURST_RST);
  endtask

  task automatic cpu_cycle(input int k);
    logic wr;
    @(posedge clk);
    kind <= l2mb_cyc_t'(k % 6);
    ouse <= k[1] | k[3];
    ogate <= (k < 8);
    be <= $urandom;
    bt <= $urandom;
    lock <= $urandom;
    cach <= $urandom;
    cfa <= $urandom;
    set <= $urandom;
    tag <= $urandom;
    sub <= $urandom;
    strb_n <= 1'b0;
    @(posedge clk);
    strb_n <= 1'b1;
    line_n <= 1'b0;
    sub_n <= $urandom;
    repeat (5) @(posedge clk);
    check(be_o, be);
    check(cn, (kind == L2MB_CYC_WRBACK || kind == L2MB_CYC_MEM_RD && cach) && !lock ? 0 : 1);
    check(bt_o, kind == L2MB_CYC_BTM ? bt : 4'h0);
    check({cfa_o, set_o, tag_o}, {cfa, set, tag});
    check({line_oe, sub_oe}, {1'b1, !sub_n});
    if (!sub_n) check(sub_o, sub);
    wr = (kind == L2MB_CYC_MEM_WR || kind == L2MB_CYC_WRBACK);
    burst(k == 7, 1 + $urandom % 3, wr, wr && ouse && !ogate);
    line_n <= 1'b1;
  endtask

  task automatic snoop(input int i);
    @(posedge clk);
    line_n <= (i == 4) ? 1'b0 : 1'b1;
    sub_n <= !i[0];
    hitm <= i[1];
    ouse <= 1'b0;
    msub <= $urandom;
    mcfa <= $urandom;
    mset <= $urandom;
    mtag <= $urandom;
    acc = 1'b0;
    repeat (5) @(posedge clk);
    snp_n <= 1'b0;
    repeat (3) @(posedge clk);
    snp_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(acc, i != 4);
    if (i != 4) begin
      check(wbs, i[0] ? L2MB_SUB_ZERO : msub);
      check({scfa, sset, stag}, {mcfa, mset, mtag});
      check(swb, i[1]);
      if (i[1]) burst(1'b0, 2, 1'b1, 1'b0);
    end
  endtask

  initial begin
    void'($urandom(32'hB705FE39));
    do_reset(1'b0, 1'b1);
    do_reset(1'b1, 1'b0);
    for (int k = 0; k < 12; k++) cpu_cycle(k);
    for (int i = 0; i < 5; i++) snoop(i);
    complete_run();
  end

  initial begin
    #400000;
    err_total++;
    complete_run();
  end
endmodule
